// ==== tpce_pkg.sv ====
// constants, tables and types of the transmit parity check / encoder select
// assumes: one character clock domain; three-level pins arrive as 2-bit codes
package tpce_pkg;

  // ----------------------------------------
  // three-level pin codes
  // ----------------------------------------
  localparam logic [1:0] LVL_LOW = 2'h0; // pin tied low
  localparam logic [1:0] LVL_MID = 2'h1; // pin left open
  localparam logic [1:0] LVL_HIGH = 2'h2; // pin tied high

  // ----------------------------------------
  // character timing and sizes
  // ----------------------------------------
  localparam logic [3:0] BIT_LAST = 4'h9; // ten bit times per character
  localparam logic [3:0] WS_LAST = 4'hF; // word sync holds 16 characters
  localparam int FIFO_DEPTH = 16; // input buffer depth in characters
  localparam int FIFO_W = 12; // data, control, parity, special select

  // ----------------------------------------
  // input word layout inside the buffer
  // ----------------------------------------
  localparam int F_DATA = 0; // eight data bits
  localparam int F_CTL = 8; // two control bits
  localparam int F_PAR = 10; // odd parity bit
  localparam int F_SC = 11; // special character select

  // ----------------------------------------
  // fixed characters and reset values
  // ----------------------------------------
  localparam logic [9:0] VIOL_POS = 10'h079; // violation, a sent first
  localparam logic [7:0] K28_5 = 8'hBC; // comma fill character
  localparam logic [4:0] K28_X = 5'h1C; // the K28 group
  localparam logic [8:0] BIST_SEED = 9'h1FF; // any non-zero start
  localparam logic RD_RESET = 1'b0; // negative running disparity

  // ----------------------------------------
  // 8b/10b sub-block tables, first bit sent in the msb
  // ----------------------------------------
  localparam logic [5:0] TAB6 [32] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [5:0] K28_6B = 6'h0F; // K28 six-bit block
  localparam logic [5:0] D7_6B = 6'h38; // balanced but flipped at rd+
  localparam logic [3:0] TAB4D [8] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
  localparam logic [3:0] TAB4K [8] = '{
    4'h4, 4'h9, 4'h5, 4'h3, 4'h2, 4'hA, 4'h6, 4'h8};
  localparam logic [3:0] ALT7_4B = 4'h7; // alternate x.7 block
  localparam logic [3:0] X3_4B = 4'hC; // balanced but flipped at rd+

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    WS_IDLE = 2'h0,
    WS_ATOM = 2'h1,
    WS_INTR = 2'h3
  } tpce_ws_t;
  typedef enum logic [1:0] {
    OS_ENC = 2'h0,
    OS_RAW = 2'h1,
    OS_VIOL = 2'h2,
    OS_VPOS = 2'h3
  } tpce_osel_t;

endpackage

// ==== tpce_fifo_if.sv ====
// carrier between the transmit front end and its input buffer
// assumes: both sides on the same clock
`timescale 1ns/1ps
interface tpce_fifo_if #(parameter int W = 12);
  logic wrValid; // producer offers a word
  logic wrReady; // buffer has room
  logic [W-1:0] wrData; // word offered
  logic rdValid; // buffer holds a word
  logic rdReady; // consumer takes the head word
  logic [W-1:0] rdData; // head word
  modport fifo (
    input wrValid, wrData, rdReady,
    output wrReady, rdValid, rdData
  );
  modport user (
    output wrValid, wrData, rdReady,
    input wrReady, rdValid, rdData
  );
endinterface

// ==== tpce_fifo.sv ====
// synchronous first-in first-out buffer for input characters
// assumes: single clock, asynchronous active-low reset
`timescale 1ns/1ps
module tpce_fifo #(
  parameter int WIDTH = tpce_pkg::FIFO_W,
  parameter int DEPTH = tpce_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic resetn,
  tpce_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH]; // storage, no reset needed
  logic [AW-1:0] wrPtr_q; // next slot to fill
  logic [AW-1:0] rdPtr_q; // head slot
  logic [AW:0] count_q; // words held
  logic [AW:0] count_d;
  logic notFull_q; // registered so ready is glitch free
  logic push;
  logic pop;

  // ----------------------------------------
  // handshakes
  // ----------------------------------------
  assign push = f.wrValid && notFull_q;
  assign pop = f.rdValid && f.rdReady;
  assign f.wrReady = notFull_q;
  assign f.rdValid = (count_q != '0);
  assign f.rdData = mem[rdPtr_q];
  assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);

  // storage write, data only
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= f.wrData;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      notFull_q <= 1'b1;
    end else begin
      wrPtr_q <= wrPtr_q + AW'(push);
      rdPtr_q <= rdPtr_q + AW'(pop);
      count_q <= count_d;
      notFull_q <= (count_d != FULL);
    end
  end
endmodule

// ==== tpce_tx_front.sv ====
// one transmit channel: parity check, character selection, 8b/10b
// encoding and the serial shifter
// assumes: host data on clk; mode, parity select, buffer error and
// self-test pins are asynchronous levels
//
// Function
// - parity bit captured with data, every mode
// - parity select low disables all checking
// - mid with encoder checks data and parity
// - high or bypass-mid adds both control bits
// - odd parity: xor of checked bits is one
// - encoded error sends violation of proper disparity
// - bypass error sends fixed positive violation pattern
// - parity errors shown on error flag
// - buffer error forces violation symbol
// - self-test sends 511-character sequence
// - K28.5 singly or 16-character word sync
// - character chosen from mode, select, control, data
// - encoder mode converts via 8b/10b rules
// - two non-overlapping special character tables
// - characters shifted out lsb first
// - two three-level pins choose nine modes
// - modes 3-8 control bits steer encoding
// - bypass passes ten bits unchanged
// - bypass ignores special select
// - bypass bit to symbol mapping fixed
// - modes 3 and 6 control code table
`timescale 1ns/1ps
module tpce_tx_front (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] txDataIn,
  input wire logic [1:0] txControlIn,
  input wire logic txOddParityIn,
  input wire logic specialCharSelect,
  input wire logic inValid,
  output logic inReady,
  input wire logic [1:0] paritySelectPin,
  input wire logic [3:0] txModeSelect,
  input wire logic alignErrorPin,
  input wire logic bistEnablePin,
  output logic serialOut,
  output logic [9:0] txCharOut,
  output logic txErrorFlag
);

  // ----------------------------------------
  // 8b/10b encoder
  // ----------------------------------------
  // returns {running disparity after, code with a in bit 0}
  function automatic logic [10:0] enc(input logic [7:0] d,
      input logic k, input logic rd);
    logic [5:0] s;
    logic [3:0] t;
    logic rdMid;
    logic [4:0] x;
    logic [2:0] y;
    logic a7;
    logic [5:0] sr;
    logic [3:0] tr;
    x = d[4:0];
    y = d[7:5];
    s = (k && x == tpce_pkg::K28_X) ? tpce_pkg::K28_6B : tpce_pkg::TAB6[x];
    // unbalanced blocks and D.7 invert at positive disparity
    if (rd && ($countones(s) != 3 || s == tpce_pkg::D7_6B)) begin
      s = ~s;
    end
    rdMid = ($countones(s) > 3) ? 1'b1 : ($countones(s) < 3) ? 1'b0 : rd;
    if (k && x == tpce_pkg::K28_X) begin
      t = tpce_pkg::TAB4K[y];
      if (!rdMid) begin
        t = ~t;
      end
    end else begin
      // alternate x.7 avoids a run of five equal bits
      a7 = (y == 3'h7) && (k ||
        (!rdMid && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
        (rdMid && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
      t = a7 ? tpce_pkg::ALT7_4B : tpce_pkg::TAB4D[y];
      if (rdMid && ($countones(t) != 2 || t == tpce_pkg::X3_4B)) begin
        t = ~t;
      end
    end
    sr = {<<{s}};
    tr = {<<{t}};
    enc = {(($countones(t) > 2) ? 1'b1 :
      ($countones(t) < 2) ? 1'b0 : rdMid), tr, sr};
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [7:0] syncA_q; // first stage, read only by syncB_q
  logic [7:0] syncB_q; // second stage, safe to decode
  logic [3:0] modeS; // transmit mode digits
  logic [1:0] parS; // parity check select
  logic alignS; // phase-align buffer error
  logic bistS; // self-test enable

  // all static pins take two flops before use
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      syncA_q <= 8'h00;
      syncB_q <= 8'h00;
    end else begin
      syncA_q <= {txModeSelect, paritySelectPin, alignErrorPin,
        bistEnablePin};
      syncB_q <= syncA_q;
    end
  end
  assign modeS = syncB_q[7:4];
  assign parS = syncB_q[3:2];
  assign alignS = syncB_q[1];
  assign bistS = syncB_q[0];

  // ----------------------------------------
  // input buffer
  // ----------------------------------------
  tpce_fifo_if #(.W(tpce_pkg::FIFO_W)) fq ();
  logic tick; // last bit time of a character
  logic [tpce_pkg::FIFO_W-1:0] w; // head word
  logic fv; // head word present

  tpce_fifo #(
    .WIDTH(tpce_pkg::FIFO_W),
    .DEPTH(tpce_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .f(fq.fifo)
  );
  // parity bit rides along with the ten bits
  assign fq.wrValid = inValid;
  assign fq.wrData = {specialCharSelect, txOddParityIn, txControlIn,
    txDataIn};
  assign inReady = fq.wrReady;
  // one word leaves per character; the shifter paces the host
  assign fq.rdReady = tick;
  assign w = fq.rdData;
  assign fv = fq.rdValid;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [3:0] bitCnt_q; // bit time within a character
  logic [9:0] shift_q; // transmit shifter
  logic [9:0] txChar_q; // last character loaded
  logic txErr_q; // error seen on last character
  logic rd_q; // running disparity, 1 is positive
  tpce_pkg::tpce_ws_t ws_q; // word sync sequencer
  tpce_pkg::tpce_ws_t ws_d;
  logic [3:0] wsCnt_q; // index of next sequence character
  logic [3:0] wsCnt_d;
  logic [8:0] lfsr_q; // self-test pattern state

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  logic [7:0] d8;
  logic [1:0] ct;
  logic bypass;
  logic atomMode;
  logic atomCont;
  logic chkOn;
  logic chkAll;
  logic parErr;
  logic isWs;
  logic isFill;
  logic isSpec;
  logic intrGo;
  logic specOk;
  logic [7:0] specByte;
  logic [1:0] lowS;

  assign tick = (bitCnt_q == tpce_pkg::BIT_LAST);
  assign d8 = w[tpce_pkg::F_DATA +: 8];
  assign ct = w[tpce_pkg::F_CTL +: 2];
  assign lowS = modeS[1:0];
  // upper digit low: bypass, whatever the lower digit
  assign bypass = (modeS[3:2] == tpce_pkg::LVL_LOW);
  assign atomMode = (modeS[3:2] == tpce_pkg::LVL_MID);
  assign atomCont = (ws_q == tpce_pkg::WS_ATOM);
  assign chkOn = (parS != tpce_pkg::LVL_LOW);
  // control bits join the check when high, or mid in bypass
  assign chkAll = (parS == tpce_pkg::LVL_HIGH) || bypass;
  // atomic sequence bodies are not checked
  assign parErr = chkOn && fv && !atomCont &&
    !(^{chkAll ? ct : 2'h0, d8, w[tpce_pkg::F_PAR]});

  // second digit gives the special select role
  // modes 3/6: ct0 low data, 01 fill or special, 11 word sync
  // modes 4/7: select and ct0 high start word sync
  // modes 5/8: select unused, 01 special, 10 fill, 11 word sync
  assign isWs = (lowS == tpce_pkg::LVL_MID) ?
    (w[tpce_pkg::F_SC] && ct[0]) : (ct == 2'h3);
  assign isFill = (lowS == tpce_pkg::LVL_HIGH) ? (ct == 2'h2) :
    (!w[tpce_pkg::F_SC] && ct == 2'h1);
  assign isSpec = (lowS == tpce_pkg::LVL_LOW) ?
    (w[tpce_pkg::F_SC] && ct == 2'h1) :
    (lowS == tpce_pkg::LVL_MID) ? (!w[tpce_pkg::F_SC] && ct == 2'h3) :
    (ct == 2'h1);
  // interruptible sequence survives only on 00 with good parity
  assign intrGo = (ws_q == tpce_pkg::WS_INTR) && fv && ct == 2'h0 &&
    !parErr;

  // extended table: K28.y, or K23/27/29/30 with y=7; reduced table:
  // codes 00-07 give K28.0-K28.7; the two input ranges never meet
  assign specOk = (d8[4:0] == tpce_pkg::K28_X) ||
    (d8[7:5] == 3'h7 && (d8[4:0] == 5'h17 || d8[4:0] == 5'h1B ||
    d8[4:0] == 5'h1D || d8[4:0] == 5'h1E)) || (d8[7:3] == 5'h00);
  assign specByte = (d8[7:3] == 5'h00) ? {d8[2:0], tpce_pkg::K28_X} : d8;

  // ----------------------------------------
  // character selection
  // ----------------------------------------
  logic [7:0] encD; // byte to encode
  logic encK; // special character
  logic encRev; // second and third sync characters
  tpce_pkg::tpce_osel_t osel;
  logic errD;
  logic [10:0] encOut;
  logic [9:0] charNext;
  logic rdD;

  // priority: buffer error, self-test, sequence continuation, idle,
  // parity, bypass, then the control code
  always_comb begin
    encD = tpce_pkg::K28_5;
    encK = 1'b1;
    encRev = 1'b0;
    osel = tpce_pkg::OS_ENC;
    errD = 1'b0;
    ws_d = tpce_pkg::WS_IDLE;
    wsCnt_d = wsCnt_q;
    if (alignS) begin
      osel = tpce_pkg::OS_VIOL;
      errD = 1'b1;
    end else if (bistS) begin
      encD = lfsr_q[7:0];
      encK = 1'b0;
    end else if (atomCont || intrGo) begin
      // K28.5 body; two characters after the first flip disparity
      encRev = (wsCnt_q == 4'h1) || (wsCnt_q == 4'h2);
      wsCnt_d = wsCnt_q + 4'h1;
      ws_d = (wsCnt_q == tpce_pkg::WS_LAST) ? tpce_pkg::WS_IDLE : ws_q;
    end else if (!fv) begin
      // nothing queued: keep the link busy with fill
    end else if (parErr) begin
      errD = 1'b1;
      // bypass ignores disparity, encoder keeps it
      osel = bypass ? tpce_pkg::OS_VPOS : tpce_pkg::OS_VIOL;
    end else if (bypass) begin
      osel = tpce_pkg::OS_RAW;
    end else if (isWs) begin
      ws_d = atomMode ? tpce_pkg::WS_ATOM : tpce_pkg::WS_INTR;
      wsCnt_d = 4'h1;
    end else if (isFill) begin
      // single K28.5
    end else if (isSpec) begin
      encD = specByte;
      if (!specOk) begin
        osel = tpce_pkg::OS_VIOL;
      end
    end else begin
      encD = d8;
      encK = 1'b0;
    end
  end

  assign encOut = enc(encD, encK, rd_q ^ encRev);
  // data bits to a..g with bit 5 as i, control to h and j
  assign charNext = (osel == tpce_pkg::OS_RAW) ? w[9:0] :
    (osel == tpce_pkg::OS_VPOS) ? tpce_pkg::VIOL_POS :
    (osel == tpce_pkg::OS_VIOL) ?
    (rd_q ? ~tpce_pkg::VIOL_POS : tpce_pkg::VIOL_POS) : encOut[9:0];
  // violation holds five ones, yet it flips the running disparity
  assign rdD = (osel == tpce_pkg::OS_ENC) ? encOut[10] :
    (osel == tpce_pkg::OS_VIOL) ? !rd_q : rd_q;

  // ----------------------------------------
  // character clock and shifter
  // ----------------------------------------
  // bit counter sets the character clock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bitCnt_q <= 4'h0;
    end else begin
      bitCnt_q <= tick ? 4'h0 : bitCnt_q + 4'h1;
    end
  end

  // load on the character clock, else shift toward bit 0
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_q <= 10'h000;
    end else begin
      shift_q <= tick ? charNext : {1'b0, shift_q[9:1]};
    end
  end

  // per-character state, one decision per character
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txChar_q <= 10'h000;
      txErr_q <= 1'b0;
      rd_q <= tpce_pkg::RD_RESET;
      ws_q <= tpce_pkg::WS_IDLE;
      wsCnt_q <= 4'h0;
    end else if (tick) begin
      txChar_q <= charNext;
      txErr_q <= errD;
      rd_q <= rdD;
      ws_q <= ws_d;
      wsCnt_q <= wsCnt_d;
    end
  end

  // self-test pattern, x^9 + x^5 + 1 repeats every 511
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lfsr_q <= tpce_pkg::BIST_SEED;
    end else if (tick && bistS) begin
      lfsr_q <= {lfsr_q[7:0], lfsr_q[8] ^ lfsr_q[4]};
    end
  end

  assign serialOut = shift_q[0];
  assign txCharOut = txChar_q;
  assign txErrorFlag = txErr_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence two_bits_out;
    (serialOut == txChar_q[0]) ##1 (serialOut == txChar_q[1]);
  endsequence

  sequence viol_loaded;
    (txChar_q == tpce_pkg::VIOL_POS) || (txChar_q == ~tpce_pkg::VIOL_POS);
  endsequence

  no_check_low_a: assert property (
    tick && parS == tpce_pkg::LVL_LOW && !alignS |=> !txErrorFlag)
    else $error("error flag raised with checking off");
  mid_ctl_free_a: assert property (
    tick && fv && !bypass && !alignS && !atomCont &&
    parS == tpce_pkg::LVL_MID && (^{d8, w[tpce_pkg::F_PAR]})
    |=> !txErrorFlag)
    else $error("control bits wrongly checked");
  high_ctl_a: assert property (
    tick && fv && !alignS && !atomCont && parS == tpce_pkg::LVL_HIGH &&
    !(^{ct, d8, w[tpce_pkg::F_PAR]}) |=> txErrorFlag)
    else $error("even parity over all bits not flagged");
  align_viol_a: assert property (
    tick && alignS |=> viol_loaded and txErrorFlag)
    else $error("buffer error did not force violation");
  bypass_pass_a: assert property (
    tick && fv && bypass && !parErr && !alignS && !bistS
    |=> txChar_q == $past(w[9:0]))
    else $error("bypass character altered");
  bypass_perr_a: assert property (
    tick && fv && bypass && parErr && !alignS && !bistS
    |=> txChar_q == tpce_pkg::VIOL_POS)
    else $error("bypass parity error pattern wrong");
  lsb_first_a: assert property (
    tick |=> two_bits_out)
    else $error("shifter not lsb first");
  ws_length_a: assert property (
    tick && atomCont && wsCnt_q == tpce_pkg::WS_LAST
    |=> ws_q == tpce_pkg::WS_IDLE)
    else $error("atomic word sync not 16 long");
  enc_perr_a: assert property (
    tick && fv && !bypass && parErr && !alignS && !bistS
    |=> viol_loaded and txErrorFlag and rd_q != $past(rd_q))
    else $error("encoded parity error not substituted");

endmodule

// ==== tpce_host_model.sv ====
// host side partner: offers one input word at a time on valid/ready
// assumes: same clock as the transmit channel, bench raises req for a word
`timescale 1ns/1ps
module tpce_host_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic inReady,
  input wire logic req,
  input wire logic [11:0] reqWord,
  output logic inValid,
  output logic [7:0] txDataIn,
  output logic [1:0] txControlIn,
  output logic txOddParityIn,
  output logic specialCharSelect,
  output logic done
);
  // ----------------------------------------
  // offer, hold until taken, then release
  // ----------------------------------------
  // after release the lines show the inverse of the last word, so a
  // design that samples without valid cannot pick up a stale match
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      inValid <= 1'b0;
      done <= 1'b0;
      {specialCharSelect, txOddParityIn, txControlIn, txDataIn} <= 12'h000;
    end else if (inValid && inReady) begin
      inValid <= 1'b0; // taken at this edge
      done <= 1'b1;
      {specialCharSelect, txOddParityIn, txControlIn, txDataIn} <=
        ~{specialCharSelect, txOddParityIn, txControlIn, txDataIn};
    end else begin
      done <= 1'b0;
      if (req && !inValid) begin
        inValid <= 1'b1;
        // parity bit travels with data and control
        {specialCharSelect, txOddParityIn, txControlIn, txDataIn} <= reqWord;
      end
    end
  end
endmodule

// ==== testbench.sv ====
// self-checking bench for one transmit channel front end
// assumes: host model feeds words; bench tracks the character ticks
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------
  // clock, reset, pins
  // ----------------------------------------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] parSel = 2'h0; // three-level parity select
  logic [3:0] modeSel = 4'h0; // two three-level mode digits
  logic alignErr = 1'b0;
  logic bistEn = 1'b0; // self-test enable
  logic req = 1'b0;
  logic [11:0] reqWord = 12'h000;
  logic inValid, inReady, done, serialOut, txErrorFlag, stallSeen = 1'b0;
  logic [7:0] txDataIn;
  logic [1:0] txControlIn;
  logic txOddParityIn, specialCharSelect;
  logic [9:0] txCharOut;
  int cnt = 0; // edges since release; loads fall on multiples of ten
  int tick = 0;
  int nFail = 0;
  int cmpCount = 0;
  localparam int LIMIT = 4000; // whole run needs under a thousand
  always #12.5 clk = ~clk;
  always @(posedge clk) if (resetn) cnt <= cnt + 1;
  // refusal seen while the buffer is full
  always @(posedge clk) if (inValid && !inReady) stallSeen <= 1'b1;
  always @(posedge clk) begin
    tick++;
    if (tick == LIMIT) begin
      nFail++;
      wrap_up();
    end
  end
  tpce_host_model tpce_host_model_inst (.clk(clk), .resetn(resetn),
    .inReady(inReady), .req(req), .reqWord(reqWord), .inValid(inValid),
    .txDataIn(txDataIn), .txControlIn(txControlIn),
    .txOddParityIn(txOddParityIn), .specialCharSelect(specialCharSelect),
    .done(done));
  // every static pin is driven by the bench
  tpce_tx_front tpce_tx_front_inst (.clk(clk), .resetn(resetn),
    .txDataIn(txDataIn), .txControlIn(txControlIn),
    .txOddParityIn(txOddParityIn), .specialCharSelect(specialCharSelect),
    .inValid(inValid), .inReady(inReady), .paritySelectPin(parSel),
    .txModeSelect(modeSel), .alignErrorPin(alignErr), .bistEnablePin(bistEn),
    .serialOut(serialOut), .txCharOut(txCharOut), .txErrorFlag(txErrorFlag));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      nFail++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // either disparity form is legal; running disparity is not tracked
  task automatic chk2(input logic [9:0] s, input logic [9:0] a, b);
    chk(s, (s === b) ? b : a);
  endtask
  task automatic put(input logic [11:0] w);
    int i;
    i = 0;
    @(posedge clk);
    req <= 1'b1;
    reqWord <= w;
    @(posedge clk);
    req <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (done !== 1'b1 && i < 200);
    if (i >= 200) chk(10'h000, 10'h3FF);
  endtask
  // sample a loaded character, then follow its ten serial bits
  task automatic take_char(output logic [9:0] c, output logic f);
    do begin
      @(posedge clk);
      #1;
    end while (cnt % 10 != 0);
    c = txCharOut;
    f = txErrorFlag;
    for (int k = 0; k < 10; k++) begin
      if (k > 0) begin
        @(posedge clk);
        #1;
      end
      chk(serialOut, {9'h000, c[k]});
    end
  endtask
  task automatic one(input logic [3:0] m, input logic [1:0] ps,
      input logic [9:0] w, input logic pb, input logic sc, input logic al,
      input logic [9:0] ea, input logic [9:0] eb, input logic ef);
    logic [9:0] c;
    logic f;
    @(posedge clk);
    modeSel <= m;
    parSel <= ps;
    alignErr <= al;
    put({sc, pb, w});
    take_char(c, f);
    chk2(c, ea, eb);
    chk({9'h000, f}, {9'h000, ef});
    $display("test mode %0h parity %0h word %0h done", m, ps, w);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  localparam logic [9:0] VN = ~tpce_pkg::VIOL_POS; // violation at rd+
  initial begin
    logic [9:0] c;
    logic f;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    one(4'h0, 2'h0, 10'h2A5, 1'b1, 1'b1, 1'b0, 10'h2A5, 10'h2A5, 1'b0);
    one(4'h0, 2'h1, 10'h2A5, 1'b1, 1'b0, 1'b0, 10'h079, 10'h079, 1'b1);
    one(4'h0, 2'h1, 10'h2A5, 1'b0, 1'b0, 1'b0, 10'h2A5, 10'h2A5, 1'b0);
    one(4'h4, 2'h1, 10'h200, 1'b1, 1'b0, 1'b0, 10'h0B9, 10'h346, 1'b0);
    one(4'h8, 2'h1, 10'h200, 1'b1, 1'b0, 1'b0, 10'h0B9, 10'h346, 1'b0);
    one(4'h6, 2'h0, 10'h200, 1'b0, 1'b0, 1'b0, 10'h17C, 10'h283, 1'b0);
    one(4'h4, 2'h2, 10'h200, 1'b1, 1'b0, 1'b0, 10'h079, VN, 1'b1);
    one(4'h4, 2'h0, 10'h100, 1'b0, 1'b0, 1'b0, 10'h17C, 10'h283, 1'b0);
    one(4'h4, 2'h0, 10'h1BC, 1'b0, 1'b1, 1'b0, 10'h17C, 10'h283, 1'b0);
    one(4'h4, 2'h0, 10'h105, 1'b0, 1'b1, 1'b0, 10'h17C, 10'h283, 1'b0);
    one(4'h4, 2'h0, 10'h100, 1'b0, 1'b0, 1'b1, 10'h079, VN, 1'b1);
    one(4'h4, 2'h0, 10'h300, 1'b0, 1'b0, 1'b0, 10'h17C, 10'h283, 1'b0);
    for (int i = 0; i < 15; i++) begin
      take_char(c, f);
      chk2(c, 10'h17C, 10'h283);
    end
    $display("test word sync done");
    // buffer: fill until refused, drain in order
    @(posedge clk);
    modeSel <= 4'h0;
    fork
      for (int i = 0; i < 24; i++) put({2'h0, 10'h100 + 10'(i)});
      for (int i = 0; i < 24; i++) begin
        take_char(c, f);
        chk(c, 10'h100 + 10'(i));
      end
    join
    chk({9'h000, stallSeen}, 10'h001);
    chk({9'h000, inReady}, 10'h001);
    $display("test buffer fill and drain done");
    // first self-test character is the seed's low byte, D31.7
    @(posedge clk);
    bistEn <= 1'b1;
    take_char(c, f);
    chk2(c, 10'h235, 10'h1CA);
    chk({9'h000, f}, 10'h000);
    $display("test self-test done");
    wrap_up();
  end
endmodule
